// file: hw/raw_defines.vh
`ifndef RAW_DEFINES_VH
`define RAW_DEFINES_VH
// Summary of operation
// - undefined repeat codes alarm once per second
// - repeat code picks second..year match rate
// - match sets alarm flag; irq if enabled
// - pointer on flags address defers alarm irq
// - flags read clears alarm flag and irq
// - backup mode alarm pulls pin with enables
// - watchdog: five-bit multiplier, two-bit resolution
// - timeout sets watchdog flag and irq
// - any watchdog write restarts the period
// - writing zero releases irq, disables watchdog
// - flags read clears watchdog flag bit 7
// - power-up clears watchdog register
// - watchdog beats frequency test on pin
// - rate code selects 32 kHz down to 1 Hz
// - wave enable switches wave onto pin outside backup
// - century bit toggles at rollover when enabled
// - battery checked at power-up and daily
// - battery-low holds until a check passes
// - oscillator fault set by reset, fail, halt
// - oscillator fault holds until written zero
// - fault irq released only by enable/flag clear
// - idle pin follows static output level bit
// - power-up defaults of control bits

// register addresses
`define RAW_A_SECONDS   5'h01
`define RAW_A_CENTURY   5'h03
`define RAW_A_CALIB     5'h08
`define RAW_A_WDOG      5'h09
`define RAW_A_AL_MONTH  5'h0A
`define RAW_A_AL_DATE   5'h0B
`define RAW_A_AL_HOUR   5'h0C
`define RAW_A_AL_MIN    5'h0D
`define RAW_A_AL_SEC    5'h0E
`define RAW_A_FLAGS     5'h0F
`define RAW_A_WAVE      5'h13
// flag bit positions
`define RAW_B_WDF       7
`define RAW_B_AF        6
`define RAW_B_BL        4
`define RAW_B_OF        2
// alarm repeat codes, bit 5 down to bit 1
`define RAW_RPT_SEC     5'h1F
`define RAW_RPT_MIN     5'h1E
`define RAW_RPT_HOUR    5'h1C
`define RAW_RPT_DAY     5'h18
`define RAW_RPT_MONTH   5'h10
`define RAW_RPT_YEAR    5'h00
// timing: 32768 Hz oscillator, 2048 cycles per 1/16 s
`define RAW_WD_TICK_LAST 11'h7FF
`define RAW_FT_BIT      5
`define RAW_DAY_SECONDS 86400
`define RAW_BOOT_DLY    3
// reset values
`define RAW_WDOG_RST    8'h00
`define RAW_CALIB_RST   8'h80
`endif

// file: hw/raw_sync.v
`default_nettype none
// two-stage synchroniser for inputs from outside the clk domain
module raw_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         nrst,
  input  wire [W-1:0] d_in,
  output wire [W-1:0] d_out
);
  reg [W-1:0] meta_ff; // first stage, read only by second stage
  reg [W-1:0] sync_ff; // settled copy

  // plain shift; no logic may look at meta_ff
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
    end else begin
      meta_ff <= d_in;
      sync_ff <= meta_ff;
    end
  end

  assign d_out = sync_ff;
endmodule // raw_sync
`default_nettype wire

// file: hw/raw_top.v
`include "raw_defines.vh"
`default_nettype none
// alarm, watchdog, square wave and flag logic of the clock
module raw_top #(
  parameter DAY_SECONDS = `RAW_DAY_SECONDS
) (
  input  wire       clk,
  input  wire       nrst,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [4:0] reg_addr,
  input  wire [7:0] reg_wdata,
  output wire [7:0] reg_rdata,
  input  wire [4:0] ptr_addr,
  input  wire       tick_sec,
  input  wire       century_roll,
  input  wire [6:0] cur_sec,
  input  wire [6:0] cur_min,
  input  wire [5:0] cur_hour,
  input  wire [5:0] cur_date,
  input  wire [4:0] cur_month,
  input  wire       osc_clk,
  input  wire       osc_stalled,
  input  wire       batt_weak_cmp,
  input  wire       on_backup,
  output wire       shared_irq_pin_o,
  output wire       shared_irq_pin_oe,
  output wire       oscillator_halt,
  output wire       update_halt,
  output wire       century_toggle,
  output wire [5:0] calib_value
);

  ////////////////////////////////////////////////////////////////////
  // input synchronisation
  wire [3:0] pin_sync;  // settled osc, fail, weak, backup
  wire       osc_s;     // settled oscillator level
  wire       fail_s;    // oscillator stall detector
  wire       weak_s;    // battery comparator
  wire       backup_s;  // battery backup mode

  raw_sync #(.W(4)) u_sync (
    .clk   (clk),
    .nrst  (nrst),
    .d_in  ({osc_clk, osc_stalled, batt_weak_cmp, on_backup}),
    .d_out (pin_sync)
  );
  assign osc_s    = pin_sync[3];
  assign fail_s   = pin_sync[2];
  assign weak_s   = pin_sync[1];
  assign backup_s = pin_sync[0];

  ////////////////////////////////////////////////////////////////////
  // register state
  reg        st_ff;         // oscillator halt
  reg        ht_ff;         // update halt
  reg        ceb_ff;        // century enable
  reg        cb_ff;         // century bit
  reg  [7:0] calib_ff;      // static level, freq test, calibration
  reg  [7:0] wdog_ff;       // fault irq enable, multiplier, resolution
  reg        afe_ff;        // alarm irq enable
  reg        square_wave_en_ff;       // square wave enable
  reg        abe_ff;        // alarm on backup enable
  reg  [4:0] al_month_ff;   // alarm month
  reg  [5:0] al_date_ff;    // alarm date
  reg  [5:0] al_hour_ff;    // alarm hour
  reg  [6:0] al_min_ff;     // alarm minutes
  reg  [6:0] al_sec_ff;     // alarm seconds
  reg  [4:0] rpt_ff;        // repeat code, bit 5 down to bit 1
  reg  [3:0] rate_ff;       // square wave rate code
  reg        wdf_ff;        // watchdog flag
  reg        af_ff;         // alarm flag
  reg        bl_ff;         // battery low flag
  reg        of_ff;         // oscillator fault flag
  reg  [7:0] rdata_ff;      // registered read data

  wire wr_at_st   = reg_wr && (reg_addr == `RAW_A_SECONDS);
  wire wr_at_cen  = reg_wr && (reg_addr == `RAW_A_CENTURY);
  wire wr_at_wdog = reg_wr && (reg_addr == `RAW_A_WDOG);
  wire wr_at_flag = reg_wr && (reg_addr == `RAW_A_FLAGS);
  wire rd_flags   = reg_rd && (reg_addr == `RAW_A_FLAGS);

  wire [4:0] wd_mult = wdog_ff[6:2];  // binary multiplier
  wire [1:0] wd_res  = wdog_ff[1:0];  // resolution code
  wire       osc_fail_irq_en    = wdog_ff[7];
  wire       wd_prog = (wd_mult != 5'h00);

  ////////////////////////////////////////////////////////////////////
  // oscillator edge detect and divider
  reg         osc_d_ff;     // previous settled osc level
  reg  [14:0] div_ff;       // ripple divider of oscillator cycles
  wire        osc_rise = osc_s & ~osc_d_ff;
  wire        osc_step = osc_rise && !st_ff; // a halted crystal gives no edges

  // halted oscillator freezes the divider, like the real crystal
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      osc_d_ff <= 1'b0;
      div_ff   <= 15'h0000;
    end else begin
      osc_d_ff <= osc_s;
      if (osc_rise && !st_ff)
        div_ff <= div_ff + 15'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // control register writes
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_ff       <= 1'b1;
      ht_ff       <= 1'b1;
      ceb_ff      <= 1'b0;
      cb_ff       <= 1'b0;
      calib_ff    <= `RAW_CALIB_RST;
      wdog_ff     <= `RAW_WDOG_RST;
      afe_ff      <= 1'b0;
      square_wave_en_ff     <= 1'b0;
      abe_ff      <= 1'b0;
      al_month_ff <= 5'h00;
      al_date_ff  <= 6'h00;
      al_hour_ff  <= 6'h00;
      al_min_ff   <= 7'h00;
      al_sec_ff   <= 7'h00;
      rpt_ff      <= 5'h00;
      rate_ff     <= 4'h0;
    end else begin
      if (wr_at_st)
        st_ff <= reg_wdata[7];
      // host write wins over a rollover in the same cycle
      if (wr_at_cen) begin
        ceb_ff <= reg_wdata[7];
        cb_ff  <= reg_wdata[6];
      end else if (century_roll && ceb_ff) begin
        cb_ff <= ~cb_ff;
      end
      if (reg_wr && reg_addr == `RAW_A_CALIB)
        calib_ff <= reg_wdata;
      if (wr_at_wdog)
        wdog_ff <= reg_wdata;
      if (reg_wr && reg_addr == `RAW_A_AL_MONTH) begin
        afe_ff      <= reg_wdata[7];
        square_wave_en_ff     <= reg_wdata[6];
        abe_ff      <= reg_wdata[5];
        al_month_ff <= reg_wdata[4:0];
      end
      if (reg_wr && reg_addr == `RAW_A_AL_DATE) begin
        rpt_ff[3]  <= reg_wdata[7];
        rpt_ff[4]  <= reg_wdata[6];
        al_date_ff <= reg_wdata[5:0];
      end
      if (reg_wr && reg_addr == `RAW_A_AL_HOUR) begin
        rpt_ff[2]  <= reg_wdata[7];
        ht_ff      <= reg_wdata[6];
        al_hour_ff <= reg_wdata[5:0];
      end
      if (reg_wr && reg_addr == `RAW_A_AL_MIN) begin
        rpt_ff[1] <= reg_wdata[7];
        al_min_ff <= reg_wdata[6:0];
      end
      if (reg_wr && reg_addr == `RAW_A_AL_SEC) begin
        rpt_ff[0] <= reg_wdata[7];
        al_sec_ff <= reg_wdata[6:0];
      end
      if (reg_wr && reg_addr == `RAW_A_WAVE)
        rate_ff <= reg_wdata[7:4];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // alarm match under the repeat code
  wire m_sec = (al_sec_ff == cur_sec);
  wire m_min = m_sec && (al_min_ff == cur_min);
  wire m_hr  = m_min && (al_hour_ff == cur_hour);
  wire m_day = m_hr && (al_date_ff == cur_date);
  wire m_yr  = m_day && (al_month_ff == cur_month);
  reg  match_lvl; // criteria met for this second

  always @* begin
    case (rpt_ff)
      `RAW_RPT_SEC:   match_lvl = 1'b1;
      `RAW_RPT_MIN:   match_lvl = m_sec;
      `RAW_RPT_HOUR:  match_lvl = m_min;
      `RAW_RPT_DAY:   match_lvl = m_hr;
      `RAW_RPT_MONTH: match_lvl = m_day;
      `RAW_RPT_YEAR:  match_lvl = m_yr;
      // a bad code fires every second so it is noticed fast
      default:        match_lvl = 1'b1;
    endcase
  end

  wire alarm_hit = tick_sec && match_lvl;

  ////////////////////////////////////////////////////////////////////
  // alarm flag and alarm interrupt
  reg  al_pend_ff;  // alarm waiting for pointer to leave flags
  reg  al_irq_ff;   // alarm interrupt active
  wire ptr_on_flags = (ptr_addr == `RAW_A_FLAGS);
  // in backup the wave is off, so the backup enable takes the place of the wave enable
  wire al_irq_ok = afe_ff && (backup_s ? abe_ff : !square_wave_en_ff);

  // set wins over the read clear in the same cycle
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      af_ff      <= 1'b0;
      al_pend_ff <= 1'b0;
      al_irq_ff  <= 1'b0;
    end else begin
      if (alarm_hit)
        af_ff <= 1'b1;
      else if (rd_flags)
        af_ff <= 1'b0;
      if (alarm_hit && al_irq_ok && ptr_on_flags)
        al_pend_ff <= 1'b1;
      else if (!ptr_on_flags || rd_flags)
        al_pend_ff <= 1'b0;
      if ((alarm_hit || al_pend_ff) && al_irq_ok && !ptr_on_flags)
        al_irq_ff <= 1'b1;
      else if (rd_flags)
        al_irq_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // watchdog counts raw oscillator edges, 2048 per 1/16 s, so a write restarts it exactly
  reg  [21:0] wd_cnt_ff;  // elapsed oscillator edges
  reg         wd_irq_ff;  // watchdog interrupt, held until zero write
  wire [21:0] wd_limit = {6'h00, wd_mult, 11'h000} << {wd_res, 1'b0};
  wire        wd_hit = wd_prog && osc_step && !wr_at_wdog
                       && (wd_cnt_ff + 22'h000001 >= wd_limit);

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wd_cnt_ff <= 22'h000000;
      wd_irq_ff <= 1'b0;
      wdf_ff    <= 1'b0;
    end else begin
      if (wr_at_wdog || !wd_prog || wd_hit)
        wd_cnt_ff <= 22'h000000;
      else if (osc_step)
        wd_cnt_ff <= wd_cnt_ff + 22'h000001;
      if (wd_hit)
        wd_irq_ff <= 1'b1;
      else if (wr_at_wdog && reg_wdata == 8'h00)
        wd_irq_ff <= 1'b0;
      if (wd_hit)
        wdf_ff <= 1'b1;
      else if (rd_flags)
        wdf_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // battery checks at power-up and every day
  reg [`RAW_BOOT_DLY-1:0] boot_ff;  // waits for settled comparator
  reg [16:0]              day_ff;   // seconds since last check
  wire boot_chk = boot_ff[`RAW_BOOT_DLY-2] & ~boot_ff[`RAW_BOOT_DLY-1];
  wire day_end  = tick_sec && (day_ff == DAY_SECONDS[16:0] - 17'h00001);

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      boot_ff <= {`RAW_BOOT_DLY{1'b0}};
      day_ff  <= 17'h00000;
      bl_ff   <= 1'b0;
    end else begin
      boot_ff <= {boot_ff[`RAW_BOOT_DLY-2:0], 1'b1};
      if (day_end)
        day_ff <= 17'h00000;
      else if (tick_sec)
        day_ff <= day_ff + 17'h00001;
      // flag only changes at a check, so a weak reading sticks
      if (boot_chk || day_end)
        bl_ff <= weak_s;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // oscillator fault flag; any set source beats the host clear
  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      of_ff <= 1'b1;
    else if (fail_s || st_ff || (wr_at_st && reg_wdata[7]))
      of_ff <= 1'b1;
    else if (wr_at_flag && !reg_wdata[`RAW_B_OF])
      of_ff <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////
  // shared pin function select, highest priority first
  reg  pin_low_ff;  // open-drain pull-down enable
  reg  pin_o_ff;    // driven level, always low
  reg  nxt_pin_low;
  wire irq_any = al_irq_ff || wd_irq_ff || (osc_fail_irq_en && of_ff);
  reg  wave;        // selected square wave

  always @* begin
    case (rate_ff)
      4'h0:    wave = 1'b1;
      4'h1:    wave = osc_s;
      default: wave = div_ff[rate_ff - 4'h1];
    endcase
  end

  always @* begin
    if (backup_s)
      nxt_pin_low = al_irq_ff && abe_ff && afe_ff;
    else if (square_wave_en_ff)
      nxt_pin_low = ~wave;
    else if (afe_ff || wd_prog || osc_fail_irq_en)
      nxt_pin_low = irq_any;
    else if (calib_ff[6])
      nxt_pin_low = ~st_ff && ~div_ff[`RAW_FT_BIT];
    else
      nxt_pin_low = ~calib_ff[7];
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_low_ff <= 1'b0;
      pin_o_ff   <= 1'b0;
    end else begin
      pin_low_ff <= nxt_pin_low;
      pin_o_ff   <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe; flags show pre-clear value
  reg [7:0] nxt_rdata;

  always @* begin
    case (reg_addr)
      `RAW_A_SECONDS:  nxt_rdata = {st_ff, 7'h00};
      `RAW_A_CENTURY:  nxt_rdata = {ceb_ff, cb_ff, 6'h00};
      `RAW_A_CALIB:    nxt_rdata = calib_ff;
      `RAW_A_WDOG:     nxt_rdata = wdog_ff;
      `RAW_A_AL_MONTH: nxt_rdata = {afe_ff, square_wave_en_ff, abe_ff, al_month_ff};
      `RAW_A_AL_DATE:  nxt_rdata = {rpt_ff[3], rpt_ff[4], al_date_ff};
      `RAW_A_AL_HOUR:  nxt_rdata = {rpt_ff[2], ht_ff, al_hour_ff};
      `RAW_A_AL_MIN:   nxt_rdata = {rpt_ff[1], al_min_ff};
      `RAW_A_AL_SEC:   nxt_rdata = {rpt_ff[0], al_sec_ff};
      `RAW_A_FLAGS:    nxt_rdata = {wdf_ff, af_ff, 1'b0, bl_ff,
                                    1'b0, of_ff, 2'b00};
      `RAW_A_WAVE:     nxt_rdata = {rate_ff, 4'h0};
      default:         nxt_rdata = 8'h00;
    endcase
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      rdata_ff <= 8'h00;
    else if (reg_rd)
      rdata_ff <= nxt_rdata;
  end

  ////////////////////////////////////////////////////////////////////
  // outputs
  assign reg_rdata         = rdata_ff;
  assign shared_irq_pin_o  = pin_o_ff;
  assign shared_irq_pin_oe = pin_low_ff;
  assign oscillator_halt   = st_ff;
  assign update_halt       = ht_ff;
  assign century_toggle    = cb_ff;
  assign calib_value       = calib_ff[5:0];

endmodule // raw_top
`default_nettype wire

// file: dv/raw_top_checker.sv
`default_nettype none
// port-level checks on the alarm/watchdog/flags block
module raw_top_checker (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       tick_sec,
  input wire logic       century_roll,
  input wire logic       shared_irq_pin_o,
  input wire logic       oscillator_halt,
  input wire logic       update_halt,
  input wire logic       century_toggle,
  input wire logic [5:0] calib_value
);
  timeunit 1ns;
  timeprecision 100ps;
  ////////////////////////////////////////////////////////////////////////////////
  // decoded accesses
  wire logic wr_halt = reg_wr && (reg_addr == 5'h01);
  wire logic wr_cent = reg_wr && (reg_addr == 5'h03);
  wire logic rd_flag = reg_rd && (reg_addr == 5'h0F);
  default clocking dck @(posedge clk);
  endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////////
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 5'h10 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_pin_drive_low: assert property (shared_irq_pin_o == 1'b0)
    else $error("open-drain value not low");
  a_halt_wr_take: assert property (wr_halt |=> oscillator_halt == $past(reg_wdata[7]))
    else $error("halt bit not written");
  a_halt_hold: assert property (!wr_halt |=> $stable(oscillator_halt))
    else $error("halt bit moved by itself");
  a_uhalt_wr_take: assert property (reg_wr && reg_addr == 5'h0C |=>
    update_halt == $past(reg_wdata[6]))
    else $error("update halt not written");
  a_calib_wr_take: assert property (reg_wr && reg_addr == 5'h08 |=>
    calib_value == $past(reg_wdata[5:0]))
    else $error("calibration bits not written");
  a_century_wr_take: assert property (wr_cent |=> century_toggle == $past(reg_wdata[6]))
    else $error("century bit not written");
  a_century_hold: assert property (!wr_cent && !century_roll |=> $stable(century_toggle))
    else $error("century bit moved without rollover");
  // tick excluded in the first read: a new alarm there wins over the clear
  a_af_read_clear: assert property ((rd_flag && !tick_sec) ##1 rd_flag |=>
    reg_rdata[6] == 1'b0)
    else $error("second flags read still shows alarm");
  c_flag_read: cover property (rd_flag);
  c_century: cover property (century_roll);
  c_halt_set: cover property (wr_halt && reg_wdata[7]);
endmodule // raw_top_checker
`default_nettype wire

// file: dv/raw_host_model.sv
`default_nettype none
// host side of the register port; the pointer steps on once after each write or read task
module raw_host_model (
  input  wire logic       clk,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [4:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic      [4:0] ptr_addr,
  input  wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
    ptr_addr = 5'h00;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one byte write; released lines show the inverse so stale values never pass
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
    ptr_addr = a + 5'h01;
  endtask
  // two back-to-back reads of one address; a second flags read shows the clear
  task automatic rd(input logic [4:0] a, output logic [7:0] q1, output logic [7:0] q2);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    q1 = reg_rdata;
    @(negedge clk);
    q2 = reg_rdata;
    reg_rd = 1'b0;
    reg_addr = ~a;
    ptr_addr = a + 5'h01;
  endtask
  // restart a stopped oscillator: halt set, then cleared at once
  task automatic restart_osc;
    wr(5'h01, 8'h80);
    wr(5'h01, 8'h00);
  endtask
endmodule // raw_host_model
`default_nettype wire

// file: dv/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk, nrst, tick_sec, century_roll, osc_clk, osc_stalled, batt_weak_cmp;
  logic       on_backup, reg_wr, reg_rd, oe_q;
  logic [6:0] cur_sec, cur_min;
  logic [5:0] cur_hour, cur_date;
  logic [4:0] cur_month, reg_addr, ptr_addr;
  logic [7:0] reg_wdata, reg_rdata, q, q2;
  wire logic  pin_o, pin_oe;
  int         err_total, comparisons, cyc, rises, i, base;
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // oscillator runs free, phase unrelated to clk
  initial begin
    osc_clk = 1'b0;
    #3.1;
    forever #62.5 osc_clk = ~osc_clk;
  end
  raw_top #(.DAY_SECONDS(5)) dut_u (.clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ptr_addr(ptr_addr),
    .tick_sec(tick_sec), .century_roll(century_roll), .cur_sec(cur_sec), .cur_min(cur_min),
    .cur_hour(cur_hour), .cur_date(cur_date), .cur_month(cur_month), .osc_clk(osc_clk),
    .osc_stalled(osc_stalled), .batt_weak_cmp(batt_weak_cmp), .on_backup(on_backup),
    .shared_irq_pin_o(pin_o), .shared_irq_pin_oe(pin_oe), .oscillator_halt(),
    .update_halt(), .century_toggle(), .calib_value());
  raw_host_model host_u (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .ptr_addr(ptr_addr), .reg_rdata(reg_rdata));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // pin pull after the sync/flop latency has settled
  task automatic pin(input logic e);
    repeat (3) @(negedge clk);
    chk({7'h00, pin_oe}, {7'h00, e});
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(negedge clk);
      tick_sec = 1'b1;
      @(negedge clk);
      tick_sec = 1'b0;
    end
  endtask
  // repeat code bits 5..1 spread over the alarm registers, fields zero
  task automatic set_rpt(input logic [4:0] c);
    host_u.wr(5'h0B, {c[3], c[4], 6'h00});
    host_u.wr(5'h0C, {c[2], 7'h00});
    host_u.wr(5'h0D, {c[1], 7'h00});
    host_u.wr(5'h0E, {c[0], 7'h00});
  endtask
  // pull counter and hang guard
  always @(posedge clk) begin
    oe_q <= pin_oe;
    if (pin_oe === 1'b1 && oe_q === 1'b0) rises <= rises + 1;
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      err_total++;
      stop_test;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [4:0] codes [7];
    int wave [4];
    codes = '{5'h1F, 5'h1E, 5'h1C, 5'h18, 5'h10, 5'h00, 5'h11};
    wave = '{0, 64, 16, 8};
    nrst = 1'b0;
    tick_sec = 1'b0;
    century_roll = 1'b0;
    osc_stalled = 1'b0;
    batt_weak_cmp = 1'b1;
    on_backup = 1'b0;
    cur_sec = 7'h00;
    cur_min = 7'h01;
    cur_hour = 6'h00;
    cur_date = 6'h00;
    cur_month = 5'h00;
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    host_u.rd(5'h09, q, q2);
    chk(q, 8'h00);
    host_u.rd(5'h08, q, q2);
    chk(q, 8'h80);
    host_u.rd(5'h0C, q, q2);
    chk(q, 8'h40);
    host_u.rd(5'h01, q, q2);
    chk(q, 8'h80);
    host_u.rd(5'h0A, q, q2);
    chk(q, 8'h00);
    host_u.wr(5'h10, 8'hFF);
    host_u.rd(5'h10, q, q2);
    chk(q, 8'h00);
    host_u.rd(5'h0F, q, q2);
    chk(q, 8'h14);
    chk({7'h00, pin_oe}, 8'h00);
    // weak battery stays flagged until the next daily check passes
    batt_weak_cmp = 1'b0;
    tick(3);
    host_u.rd(5'h0F, q, q2);
    chk(q, 8'h14);
    tick(4);
    host_u.rd(5'h0F, q, q2);
    chk(q, 8'h04);
    host_u.wr(5'h08, 8'h00);
    pin(1'b1);
    host_u.wr(5'h08, 8'h80);
    pin(1'b0);
    host_u.restart_osc;
    host_u.rd(5'h0F, q, q2);
    chk(q, 8'h04);
    host_u.wr(5'h0F, 8'h00);
    host_u.rd(5'h0F, q, q2);
    chk(q, 8'h00);
    // seconds match, minutes do not
    for (i = 0; i < 7; i++) begin
      set_rpt(codes[i]);
      host_u.rd(5'h0F, q, q2);
      tick(1);
      host_u.rd(5'h0F, q, q2);
      chk(q, (i < 2 || i == 6) ? 8'h40 : 8'h00);
    end
    host_u.wr(5'h0A, 8'h80);
    set_rpt(5'h1F);
    tick(1);
    pin(1'b0);
    host_u.rd(5'h08, q, q2);
    pin(1'b1);
    host_u.rd(5'h0F, q, q2);
    chk(q, 8'h40);
    chk(q2, 8'h00);
    pin(1'b0);
    host_u.wr(5'h0A, 8'hA0);
    @(negedge clk);
    on_backup = 1'b1;
    repeat (4) @(negedge clk);
    tick(1);
    pin(1'b1);
    host_u.rd(5'h0F, q, q2);
    pin(1'b0);
    on_backup = 1'b0;
    for (i = 0; i < 2; i++) begin
      host_u.wr(5'h03, i ? 8'h40 : 8'h80);
      @(negedge clk);
      century_roll = 1'b1;
      @(negedge clk);
      century_roll = 1'b0;
      host_u.rd(5'h03, q, q2);
      chk(q, i ? 8'h40 : 8'hC0);
    end
    // 1000 clk cycles hold 64 oscillator periods
    for (i = 0; i < 4; i++) begin
      host_u.wr(5'h13, {i[3:0], 4'h0});
      host_u.wr(5'h0A, 8'h40);
      base = rises;
      repeat (1000) @(negedge clk);
      chk({7'h00, rises - base >= wave[i] - 1 && rises - base <= wave[i] + 1}, 8'h01);
    end
    host_u.wr(5'h0A, 8'h00);
    // 1/16 s = 2048 oscillator edges = 32000 clk; frequency test requested too
    host_u.wr(5'h08, 8'hC0);
    host_u.wr(5'h09, 8'h04);
    base = rises;
    repeat (20000) @(negedge clk);
    host_u.wr(5'h09, 8'h04);
    repeat (20000) @(negedge clk);
    chk({7'h00, rises != base}, 8'h00);
    for (i = 0; i < 14000 && pin_oe !== 1'b1; i++) @(negedge clk);
    chk({7'h00, i > 11800 && i < 12200}, 8'h01);
    // frequency test off, so the pin is quiet once the watchdog is disabled
    host_u.wr(5'h08, 8'h80);
    host_u.rd(5'h0F, q, q2);
    chk(q, 8'h80);
    chk(q2, 8'h00);
    pin(1'b1);
    host_u.wr(5'h09, 8'h00);
    pin(1'b0);
    host_u.wr(5'h09, 8'h80);
    @(negedge clk);
    osc_stalled = 1'b1;
    repeat (4) @(negedge clk);
    osc_stalled = 1'b0;
    pin(1'b1);
    host_u.rd(5'h0F, q, q2);
    chk(q, 8'h04);
    pin(1'b1);
    host_u.wr(5'h0F, 8'h00);
    pin(1'b0);
    stop_test;
  end
endmodule // tb_top
bind raw_top raw_top_checker chk_u (.clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .tick_sec(tick_sec),
  .century_roll(century_roll), .shared_irq_pin_o(shared_irq_pin_o),
  .oscillator_halt(oscillator_halt), .update_halt(update_halt),
  .century_toggle(century_toggle), .calib_value(calib_value));
`default_nettype wire
